// ==== hw/tmw_timer.sv ====
// tmw_timer: three waveform timer channels behind an AHB-Lite slave.
// assumes count_tick_in marks the active edge of each counter clock and
// that all pins and ticks are synchronous to clk_sys_in.
`timescale 1ns/1ps
// Summary of operation
// RULE_01: shape 00 counts up, wraps at full.
// RULE_02: shape 00 triggers reset the count anytime.
// RULE_03: shapes 00/01 never trigger on C match.
// RULE_04: C match stops and/or disables the clock.
// RULE_05: shape 10 counts to C, clears, repeats.
// RULE_06: shape 10 triggers reset the count anytime.
// RULE_07: shape 01 triangles between zero and full.
// RULE_08: up-down shapes reverse direction on trigger.
// RULE_09: shape 11 triangles between zero and C.
// RULE_10: event source: three clock lines or pin B.
// RULE_11: edge select; zero means no event.
// RULE_12: source 0 makes pin B input only.
// RULE_13: events trigger only with trigger enable.
// RULE_14: group sync and software trigger always trigger.
// RULE_15: events set, clear or toggle outputs.
// RULE_16: pin B driven only when an output.
// RULE_17: 0x40 channel windows, group registers after.
// RULE_18: A/B compare writable only in waveform.
// RULE_19: trigger acts at next counter clock edge.
// RULE_20: enable-set and enable-clear edit the mask.
module tmw_timer
    import tmw_pkg::*;
#(
    parameter int NUM_CH = 3,
    parameter int CNT_W = 16
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic [2:0] count_tick_in,
    input wire logic [2:0] ext_clock_line_in,
    output logic [2:0] wave_pin_first_out,
    input wire logic [2:0] wave_pin_second_in,
    output logic [2:0] wave_pin_second_out,
    output logic [2:0] wave_pin_second_oe_out
);
    // the map and the state layout are built for exactly this shape
    if (NUM_CH != 3 || CNT_W != 16) begin : g_bad_param
        $error("tmw_timer supports only three 16-bit channels");
    end

    tmw_state_s s_q; // all state of the block
    tmw_state_s s_d; // next value
    logic take; // address phase accepted
    logic sync_cmd; // group sync written this cycle
    logic [2:0] go; // counting edge per channel
    logic [2:0] trig_now; // trigger raised this cycle
    logic [2:0] ev_det; // selected edge seen
    logic [2:0] sw_now; // software or group trigger
    logic [2:0] ev_lvl; // selected event source level
    logic [2:0] wr_ch; // data-phase write hits channel
    logic [2:0] ma; // first compare match
    logic [2:0] mb; // second compare match
    logic [2:0] mc; // period compare match
    logic [5:0] woff; // data-phase offset in window
    logic [1:0] src [3]; // event source per channel
    tmw_shape_e shape [3]; // count shape per channel
    logic [15:0] top [3]; // turning point of up-down shapes

    // output action decode, used for both pins
    function automatic logic act(input logic [1:0] a, input logic lvl);
        case (tmw_act_e'(a))
            TMW_ACT_SET: act = 1'b1;
            TMW_ACT_CLR: act = 1'b0;
            TMW_ACT_TOG: act = ~lvl;
            default: act = lvl;
        endcase
    endfunction

    // next-state logic for bus, channels and pins
    always_comb begin
        s_d = s_q;
        s_d.ready = 1'b1; // zero wait states
        s_d.rdata = 32'h0000_0000;
        // only whole-word transfers are served; others read zero
        take = hsel_in && htrans_in[1] && hready_in &&
               (hsize_in == HSIZE_WORD);
        s_d.wr_pend = take && hwrite_in;
        s_d.wr_addr = take ? haddr_in[7:0] : s_q.wr_addr;
        woff = {s_q.wr_addr[5:2], 2'b00};
        // one sync write triggers all channels together
        sync_cmd = s_q.wr_pend && (s_q.wr_addr == OFF_GCMD) &&
                   hwdata_in[GCMD_SYNC];
        if (s_q.wr_pend && s_q.wr_addr == OFF_GCFG) begin
            s_d.gcfg = hwdata_in[GCFG_W-1:0];
        end
        if (take && !hwrite_in && haddr_in[7:0] == OFF_GCFG) begin
            s_d.rdata = {26'h0, s_q.gcfg};
        end
        for (int i = 0; i < 3; i++) begin
            // window decode: bits 7:6 pick the channel
            wr_ch[i] = s_q.wr_pend && (s_q.wr_addr[7:6] == 2'(i)); // RULE_17
            shape[i] = tmw_shape_e'(s_q.ch[i].cfg[CFG_SHAPE +: 2]);
            src[i] = s_q.ch[i].cfg[CFG_SRC +: 2];
            top[i] = (shape[i] == TMW_UPDN_RC) ? s_q.ch[i].rc : CNT_FULL;
            // register writes land in the data phase
            if (wr_ch[i] && woff == OFF_CFG) begin
                s_d.ch[i].cfg = hwdata_in;
            end
            // compare A/B are read-only while capturing
            if (wr_ch[i] && woff == OFF_RA && s_q.ch[i].cfg[CFG_WAVE]) begin
                s_d.ch[i].ra = hwdata_in[15:0]; // RULE_18
            end
            if (wr_ch[i] && woff == OFF_RB && s_q.ch[i].cfg[CFG_WAVE]) begin
                s_d.ch[i].rb = hwdata_in[15:0]; // RULE_18
            end
            if (wr_ch[i] && woff == OFF_RC) begin
                s_d.ch[i].rc = hwdata_in[15:0];
            end
            if (wr_ch[i] && woff == OFF_IER) begin
                s_d.ch[i].mask = s_q.ch[i].mask | hwdata_in[7:0]; // RULE_20
            end
            if (wr_ch[i] && woff == OFF_IDR) begin
                s_d.ch[i].mask = s_q.ch[i].mask & ~hwdata_in[7:0]; // RULE_20
            end
            // event source: pin B or one of the clock lines
            if (src[i] == SRC_PIN) begin
                ev_lvl[i] = wave_pin_second_in[i]; // RULE_10
            end else begin
                ev_lvl[i] = ext_clock_line_in[2'(src[i] - 2'd1)]; // RULE_10
            end
            s_d.ch[i].ev_prev = ev_lvl[i];
            // edge field zero yields no event at all
            ev_det[i] = (s_q.ch[i].cfg[CFG_EDG] &&
                         ev_lvl[i] && !s_q.ch[i].ev_prev) ||
                        (s_q.ch[i].cfg[CFG_EDG + 1] &&
                         !ev_lvl[i] && s_q.ch[i].ev_prev); // RULE_11
            sw_now[i] = (wr_ch[i] && woff == OFF_CMD &&
                         hwdata_in[CMD_SWTRG]) || sync_cmd; // RULE_14
            // the event triggers only when enabled for that
            trig_now[i] = sw_now[i] ||
                          (ev_det[i] && s_q.ch[i].cfg[CFG_ETRG]); // RULE_13
            go[i] = s_q.ch[i].clk_on && s_q.ch[i].run && count_tick_in[i];
            ma[i] = go[i] && (s_q.ch[i].cv == s_q.ch[i].ra);
            // no B compare while pin B is the event input
            mb[i] = go[i] && (s_q.ch[i].cv == s_q.ch[i].rb) &&
                    (src[i] != SRC_PIN); // RULE_12
            mc[i] = go[i] && (s_q.ch[i].cv == s_q.ch[i].rc);
            // counting step; a held trigger is served here
            if (go[i]) begin
                if (s_q.ch[i].pend) begin
                    if (shape[i] == TMW_UPDN_FULL ||
                        shape[i] == TMW_UPDN_RC) begin
                        s_d.ch[i].down = !s_q.ch[i].down; // RULE_08 RULE_19
                    end else begin
                        s_d.ch[i].cv = CNT_ZERO; // RULE_02 RULE_06 RULE_19
                    end
                end else begin
                    case (shape[i])
                        // C match is ignored here, no trigger
                        TMW_UP_FULL: begin
                            s_d.ch[i].cv =
                                16'(s_q.ch[i].cv + 16'd1); // RULE_01 RULE_03
                        end
                        TMW_UP_RC: begin
                            if (s_q.ch[i].cv == s_q.ch[i].rc) begin
                                s_d.ch[i].cv = CNT_ZERO; // RULE_05
                            end else begin
                                s_d.ch[i].cv =
                                    16'(s_q.ch[i].cv + 16'd1); // RULE_05
                            end
                        end
                        default: begin
                            // up-down shapes turn at top and at zero
                            if (!s_q.ch[i].down) begin
                                if (s_q.ch[i].cv >= top[i]) begin
                                    s_d.ch[i].down = 1'b1; // RULE_07 RULE_09
                                    s_d.ch[i].cv = 16'(s_q.ch[i].cv - 16'd1);
                                end else begin
                                    s_d.ch[i].cv = 16'(s_q.ch[i].cv + 16'd1);
                                end
                            end else if (s_q.ch[i].cv == CNT_ZERO) begin
                                s_d.ch[i].down = 1'b0; // RULE_07 RULE_09
                                s_d.ch[i].cv = 16'(s_q.ch[i].cv + 16'd1);
                            end else begin
                                s_d.ch[i].cv = 16'(s_q.ch[i].cv - 16'd1);
                            end
                        end
                    endcase
                end
                // C match may stop and/or disable the counter clock
                if (mc[i] && s_q.ch[i].cfg[CFG_STOP]) begin
                    s_d.ch[i].run = 1'b0; // RULE_04
                end
                if (mc[i] && s_q.ch[i].cfg[CFG_DIS]) begin
                    s_d.ch[i].clk_on = 1'b0; // RULE_04
                end
            end
            // clock commands; disable beats enable in one write
            if (wr_ch[i] && woff == OFF_CMD) begin
                if (hwdata_in[CMD_CLKDIS]) begin
                    s_d.ch[i].clk_on = 1'b0;
                end else if (hwdata_in[CMD_CLKEN]) begin
                    s_d.ch[i].clk_on = 1'b1;
                end
            end
            // a trigger starts an enabled clock and waits for a tick
            s_d.ch[i].pend = (s_q.ch[i].pend && !go[i]) ||
                trig_now[i]; // RULE_19
            if (trig_now[i] && s_d.ch[i].clk_on) begin
                s_d.ch[i].run = 1'b1;
            end
            // sticky flags: set wins over clear-on-read
            s_d.ch[i].flags = s_q.ch[i].flags;
            if (take && !hwrite_in && haddr_in[7:6] == 2'(i) &&
                {haddr_in[5:2], 2'b00} == OFF_SR) begin
                s_d.ch[i].flags = 8'h00;
            end
            s_d.ch[i].flags[SR_OVF] = s_d.ch[i].flags[SR_OVF] ||
                (go[i] && !s_q.ch[i].pend && s_q.ch[i].cv == CNT_FULL &&
                 !shape[i][0]);
            s_d.ch[i].flags[SR_CPA] = s_d.ch[i].flags[SR_CPA] || ma[i];
            s_d.ch[i].flags[SR_CPB] = s_d.ch[i].flags[SR_CPB] || mb[i];
            s_d.ch[i].flags[SR_CPC] = s_d.ch[i].flags[SR_CPC] || mc[i];
            s_d.ch[i].flags[SR_ETRG] = s_d.ch[i].flags[SR_ETRG] || ev_det[i];
            // output controller, later events take priority
            if (s_q.ch[i].cfg[CFG_WAVE]) begin
                s_d.ch[i].pin_a = act(ma[i] ? s_q.ch[i].cfg[CFG_ACPA +: 2] :
                    TMW_ACT_NONE, s_q.ch[i].pin_a); // RULE_15
                s_d.ch[i].pin_a = act(mc[i] ? s_q.ch[i].cfg[CFG_ACPC +: 2] :
                    TMW_ACT_NONE, s_d.ch[i].pin_a); // RULE_15
                s_d.ch[i].pin_a = act(ev_det[i] ?
                    s_q.ch[i].cfg[CFG_AEEV +: 2] : TMW_ACT_NONE,
                    s_d.ch[i].pin_a); // RULE_15
                s_d.ch[i].pin_a = act(sw_now[i] ?
                    s_q.ch[i].cfg[CFG_ASW +: 2] : TMW_ACT_NONE,
                    s_d.ch[i].pin_a); // RULE_15
            end
            // pin B acts only while it is an output
            if (s_q.ch[i].cfg[CFG_WAVE] && src[i] != SRC_PIN) begin
                s_d.ch[i].pin_b = act(mb[i] ? s_q.ch[i].cfg[CFG_BCPB +: 2] :
                    TMW_ACT_NONE, s_q.ch[i].pin_b); // RULE_16
                s_d.ch[i].pin_b = act(mc[i] ? s_q.ch[i].cfg[CFG_BCPC +: 2] :
                    TMW_ACT_NONE, s_d.ch[i].pin_b); // RULE_15
                s_d.ch[i].pin_b = act(ev_det[i] ?
                    s_q.ch[i].cfg[CFG_BEEV +: 2] : TMW_ACT_NONE,
                    s_d.ch[i].pin_b); // RULE_15
                s_d.ch[i].pin_b = act(sw_now[i] ?
                    s_q.ch[i].cfg[CFG_BSW +: 2] : TMW_ACT_NONE,
                    s_d.ch[i].pin_b); // RULE_15
            end
            s_d.ch[i].pin_b_oe = s_d.ch[i].cfg[CFG_WAVE] &&
                (s_d.ch[i].cfg[CFG_SRC +: 2] != SRC_PIN); // RULE_12 RULE_16
            // read data prepared in the address phase
            if (take && !hwrite_in && haddr_in[7:6] == 2'(i)) begin
                case ({haddr_in[5:2], 2'b00})
                    OFF_CFG: s_d.rdata = s_q.ch[i].cfg;
                    OFF_CV: s_d.rdata = {16'h0000, s_q.ch[i].cv};
                    OFF_RA: s_d.rdata = {16'h0000, s_q.ch[i].ra};
                    OFF_RB: s_d.rdata = {16'h0000, s_q.ch[i].rb};
                    OFF_RC: s_d.rdata = {16'h0000, s_q.ch[i].rc};
                    OFF_SR: s_d.rdata = {13'h0, s_q.ch[i].pin_b,
                        s_q.ch[i].pin_a, s_q.ch[i].clk_on, 8'h00,
                        s_q.ch[i].flags};
                    OFF_IMR: s_d.rdata = {24'h00_0000, s_q.ch[i].mask};
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // single state register
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            s_q <= '0;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ports straight from state flops; hresp_out tied low
    assign hrdata_out = s_q.rdata;
    assign hreadyout_out = s_q.ready;
    assign hresp_out = 1'b0;
    for (genvar g = 0; g < 3; g++) begin : g_pins
        assign wave_pin_first_out[g] = s_q.ch[g].pin_a;
        assign wave_pin_second_out[g] = s_q.ch[g].pin_b;
        assign wave_pin_second_oe_out[g] = s_q.ch[g].pin_b_oe;
    end

    // checks on the channel that each scenario drives
    logic [1:0] sh0;
    assign sh0 = s_q.ch[0].cfg[CFG_SHAPE +: 2];
    // all checks sample on the system clock, off during reset
    default clocking cb_chk @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);

    AST_WRAP_FULL: assert property ( // RULE_01
        go[0] && sh0 == 2'b00 && !s_q.ch[0].pend &&
        s_q.ch[0].cv == CNT_FULL |=> s_q.ch[0].cv == CNT_ZERO)
        else $error("shape 00 did not wrap to zero");
    AST_TRIG_ZERO: assert property ( // RULE_02
        go[0] && !sh0[0] && s_q.ch[0].pend |=> s_q.ch[0].cv == CNT_ZERO)
        else $error("trigger did not clear the count");
    AST_NO_C_TRIG: assert property ( // RULE_03
        go[0] && sh0 == 2'b00 && !s_q.ch[0].pend &&
        s_q.ch[0].cv == s_q.ch[0].rc && s_q.ch[0].cv != CNT_FULL
        |=> s_q.ch[0].cv == 16'($past(s_q.ch[0].cv) + 16'd1))
        else $error("C match acted as trigger in shape 00");
    AST_C_STOP: assert property ( // RULE_04
        mc[1] && s_q.ch[1].cfg[CFG_STOP] && !trig_now[1]
        |=> !s_q.ch[1].run)
        else $error("C match did not stop the clock");
    AST_C_CLEAR: assert property ( // RULE_05
        go[1] && s_q.ch[1].cfg[CFG_SHAPE +: 2] == 2'b10 &&
        !s_q.ch[1].pend && s_q.ch[1].cv == s_q.ch[1].rc
        |=> s_q.ch[1].cv == CNT_ZERO)
        else $error("shape 10 did not clear at C");
    AST_REVERSE: assert property ( // RULE_08
        go[2] && s_q.ch[2].cfg[CFG_SHAPE] && s_q.ch[2].pend
        |=> s_q.ch[2].down != $past(s_q.ch[2].down))
        else $error("trigger did not reverse direction");
    AST_EDGE_NONE: assert property ( // RULE_11
        s_q.ch[0].cfg[CFG_EDG +: 2] == 2'b00 |-> !ev_det[0])
        else $error("event seen with edge select off");
    AST_PIN_B_IN: assert property ( // RULE_16
        s_q.ch[0].cfg[CFG_SRC +: 2] == SRC_PIN
        |-> !wave_pin_second_oe_out[0] && !mb[0])
        else $error("pin B driven while an event input");
    AST_RO_CAPTURE: assert property ( // RULE_18
        !s_q.ch[0].cfg[CFG_WAVE] |=> s_q.ch[0].ra == $past(s_q.ch[0].ra))
        else $error("compare A changed in capture");
    AST_MASK_SET: assert property ( // RULE_20
        wr_ch[2] && woff == OFF_IER
        |=> (s_q.ch[2].mask & $past(hwdata_in[7:0])) == $past(hwdata_in[7:0]))
        else $error("mask bits not set");
    COV_WRAP: cover property (@(posedge clk_sys_in) go[0] &&
        s_q.ch[0].cv == CNT_FULL);
    COV_REVERSE: cover property (@(posedge clk_sys_in) go[2] &&
        s_q.ch[2].cfg[CFG_SHAPE] && s_q.ch[2].pend);
    COV_EVENT_TRIG: cover property (@(posedge clk_sys_in) ev_det[0] &&
        trig_now[0]);
endmodule

// ==== hw/tmw_pkg.sv ====
// tmw_pkg: constants, field layout and state types of the waveform timer.
// assumes a 32-bit word-aligned register window of 0x100 bytes.
package tmw_pkg;
    // per-channel register offsets inside a 0x40 window
    localparam logic [5:0] OFF_CMD = 6'h00;
    localparam logic [5:0] OFF_CFG = 6'h04;
    localparam logic [5:0] OFF_CV = 6'h10;
    localparam logic [5:0] OFF_RA = 6'h14;
    localparam logic [5:0] OFF_RB = 6'h18;
    localparam logic [5:0] OFF_RC = 6'h1C;
    localparam logic [5:0] OFF_SR = 6'h20;
    localparam logic [5:0] OFF_IER = 6'h24;
    localparam logic [5:0] OFF_IDR = 6'h28;
    localparam logic [5:0] OFF_IMR = 6'h2C;
    // group registers after the three channel windows
    localparam logic [7:0] OFF_GCMD = 8'hC0;
    localparam logic [7:0] OFF_GCFG = 8'hC4;
    localparam int GCFG_W = 6;
    // command bits
    localparam int CMD_CLKEN = 0;
    localparam int CMD_CLKDIS = 1;
    localparam int CMD_SWTRG = 2;
    localparam int GCMD_SYNC = 0;
    // configuration field positions
    localparam int CFG_STOP = 6;
    localparam int CFG_DIS = 7;
    localparam int CFG_EDG = 8;
    localparam int CFG_SRC = 10;
    localparam int CFG_ETRG = 12;
    localparam int CFG_SHAPE = 13;
    localparam int CFG_WAVE = 15;
    localparam int CFG_ACPA = 16;
    localparam int CFG_ACPC = 18;
    localparam int CFG_AEEV = 20;
    localparam int CFG_ASW = 22;
    localparam int CFG_BCPB = 24;
    localparam int CFG_BCPC = 26;
    localparam int CFG_BEEV = 28;
    localparam int CFG_BSW = 30;
    // flag positions
    localparam int SR_OVF = 0;
    localparam int SR_CPA = 2;
    localparam int SR_CPB = 3;
    localparam int SR_CPC = 4;
    localparam int SR_ETRG = 7;
    localparam logic [15:0] CNT_FULL = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [1:0] SRC_PIN = 2'b00;
    localparam logic [2:0] HSIZE_WORD = 3'b010;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        TMW_UP_FULL = 2'b00,
        TMW_UPDN_FULL = 2'b01,
        TMW_UP_RC = 2'b10,
        TMW_UPDN_RC = 2'b11
    } tmw_shape_e;

    typedef enum logic [1:0] {
        TMW_ACT_NONE = 2'b00,
        TMW_ACT_SET = 2'b01,
        TMW_ACT_CLR = 2'b10,
        TMW_ACT_TOG = 2'b11
    } tmw_act_e;

    typedef struct packed {
        logic [31:0] cfg;
        logic [15:0] cv;
        logic [15:0] ra;
        logic [15:0] rb;
        logic [15:0] rc;
        logic [7:0] flags;
        logic [7:0] mask;
        logic clk_on;
        logic run;
        logic down;
        logic pend;
        logic ev_prev;
        logic pin_a;
        logic pin_b;
        logic pin_b_oe;
    } tmw_chan_s;

    typedef struct packed {
        tmw_chan_s [2:0] ch;
        logic [5:0] gcfg;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
    } tmw_state_s;
endpackage

// ==== test/tmw_evt_src.sv ====
// tmw_evt_src: event sources on the clock lines and loads on pin two.
// assumes requests come from the bench just after rising clock edges.
`timescale 1ns/1ps
module tmw_evt_src (
    input wire logic clk_sys_in,
    input wire logic [2:0] line_req_in,
    input wire logic [2:0] pin_req_in,
    input wire logic [2:0] pin_out_in,
    input wire logic [2:0] pin_oe_in,
    output logic [2:0] ext_line_out = 3'h0,
    output logic [2:0] pin_level_out
);
    // clock lines lag one cycle, like a real driver behind a pad
    always @(posedge clk_sys_in) begin
        ext_line_out <= line_req_in;
    end
    // resolved pin: the channel wins while it drives, else the source
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_level_out[i] = pin_oe_in[i] ? pin_out_in[i] : pin_req_in[i];
        end
    end
endmodule

// ==== test/tb_top.sv ====
// tb_top: self-checking bench for the three-channel waveform timer.
// assumes a zero-wait bus slave and the event source model beside it.
`timescale 1ns/1ps
module tb_top;
    import tmw_pkg::*;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic hsel_in = 1'b0;
    logic hwrite_in = 1'b0;
    logic [1:0] htrans_in = 2'b00;
    logic [31:0] haddr_in = 32'h0000_0000;
    logic [31:0] hwdata_in = 32'h0000_0000;
    logic [2:0] count_tick_in = 3'h0;
    logic [3:0] ev_req = 4'h0; // bit 0 pin two of channel 0, 3:1 lines
    logic [31:0] hrdata_out;
    logic hreadyout_out, hresp;
    logic [2:0] ext_line, pin_a, pin_b, pin_b_oe, pin_b_lvl;
    logic [63:0] exp_q[$]; // {mask, expected} per pending read
    logic [63:0] note;
    logic rd_dp = 1'b0;
    logic [31:0] r0, r1;
    logic pin_exp = 1'b0;
    logic [7:0] rst_a[10] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
        8'h2C, 8'h08, 8'hC4, 8'hFC};
    int error_cnt = 0;
    int n_checks = 0;
    // 20 MHz system clock
    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    tmw_timer dut_u (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
        .hwrite_in(hwrite_in), .hsize_in(HSIZE_WORD), .hwdata_in(hwdata_in),
        .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp),
        .count_tick_in(count_tick_in), .ext_clock_line_in(ext_line),
        .wave_pin_first_out(pin_a), .wave_pin_second_in(pin_b_lvl),
        .wave_pin_second_out(pin_b), .wave_pin_second_oe_out(pin_b_oe));
    tmw_evt_src src_u (.clk_sys_in(clk_sys_in), .line_req_in(ev_req[3:1]),
        .pin_req_in({2'b00, ev_req[0]}), .pin_out_in(pin_b),
        .pin_oe_in(pin_b_oe), .ext_line_out(ext_line),
        .pin_level_out(pin_b_lvl));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // watcher: each read data phase is matched against the oldest note
    always @(posedge clk_sys_in) begin
        if (rd_dp && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            chk(hrdata_out & note[63:32], note[31:0]);
            chk({31'h0, hresp}, 32'h0000_0000);
        end
        rd_dp <= hsel_in && htrans_in[1] && !hwrite_in && hreadyout_out;
    end
    // one single word transfer; a read notes its expected value first
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] m = 32'hFFFF_FFFF);
        hsel_in <= 1'b1;
        haddr_in <= {24'h00_0000, a};
        htrans_in <= 2'b10;
        hwrite_in <= wr;
        if (!wr) exp_q.push_back({m, d & m});
        do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'b00;
        hsel_in <= 1'b0;
        hwdata_in <= wr ? d : 32'h0000_0000;
        do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
    endtask
    // idle edges first so a pending trigger has landed before the ticks
    task automatic tick(input int ch, input int n);
        repeat (2) @(posedge clk_sys_in);
        for (int i = 0; i < n; i++) begin
            count_tick_in[ch] <= 1'b1;
            @(posedge clk_sys_in);
        end
        count_tick_in <= 3'h0;
        @(posedge clk_sys_in);
    endtask
    // pulses longer than one system clock, so both edges are seen
    task automatic pulse(input int ln);
        ev_req[ln] <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        ev_req[ln] <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
    endtask
    function automatic logic [31:0] mk(input logic [1:0] shp,
        input logic [1:0] src, input logic [1:0] edg, input logic trg);
        return (32'h0000_0001 << CFG_WAVE) | ({30'h0, shp} << CFG_SHAPE)
            | ({30'h0, src} << CFG_SRC) | ({30'h0, edg} << CFG_EDG)
            | ({31'h0, trg} << CFG_ETRG);
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog: the whole run needs about 66000 cycles
    initial begin
        #(90000 * 50);
        error_cnt++;
        close_out();
    end
    initial begin
        void'($urandom(24));
        repeat (4) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        foreach (rst_a[i]) bus(1'b0, rst_a[i], 32'h0000_0000);
        r0 = {16'h0000, 16'($urandom)};
        r1 = {16'h0000, 16'($urandom)};
        bus(1'b1, {2'd0, OFF_CV}, r0);
        bus(1'b1, {2'd0, OFF_RA}, r0);
        bus(1'b0, {2'd0, OFF_RA}, 32'h0000_0000);
        bus(1'b1, {2'd0, OFF_CFG}, mk(2'b00, 2'b01, 2'b00, 1'b0));
        bus(1'b1, {2'd0, OFF_RA}, r0);
        bus(1'b1, {2'd0, OFF_RB}, r1);
        bus(1'b1, OFF_GCFG, r1);
        bus(1'b0, {2'd0, OFF_RA}, r0);
        bus(1'b0, {2'd0, OFF_RB}, r1);
        bus(1'b0, OFF_GCFG, r1, 32'h0000_003F);
        bus(1'b0, {2'd0, OFF_CV}, 32'h0000_0000);
        bus(1'b1, {2'd2, OFF_IER}, 32'h0000_0015);
        bus(1'b1, {2'd2, OFF_IDR}, 32'h0000_0004);
        bus(1'b0, {2'd2, OFF_IMR}, 32'h0000_0011);
        $display("test registers done");
        // shape 00 with a low C value that must not restart the count
        bus(1'b1, {2'd0, OFF_RC}, 32'h0000_0003);
        bus(1'b1, {2'd0, OFF_CMD}, 32'h0000_0005);
        tick(0, 11);
        bus(1'b0, {2'd0, OFF_CV}, 32'h0000_000A);
        bus(1'b1, {2'd0, OFF_CMD}, 32'h0000_0004);
        bus(1'b0, {2'd0, OFF_CV}, 32'h0000_000A);
        tick(0, 1);
        bus(1'b0, {2'd0, OFF_CV}, 32'h0000_0000);
        tick(0, 65535);
        bus(1'b0, {2'd0, OFF_CV}, 32'h0000_FFFF);
        tick(0, 1);
        bus(1'b0, {2'd0, OFF_CV}, 32'h0000_0000);
        bus(1'b0, {2'd0, OFF_SR}, 32'h0001_0001, 32'h0001_0001);
        $display("test shape 00 done");
        // shape 10: sw sets both pins, A clears pin one, C clears pin two
        r0 = 32'd5 + ($urandom % 8);
        bus(1'b1, {2'd1, OFF_CFG}, mk(2'b10, 2'b01, 2'b00, 1'b0)
            | 32'h4842_00C0);
        bus(1'b1, {2'd1, OFF_RA}, 32'h0000_0002);
        bus(1'b1, {2'd1, OFF_RC}, r0);
        bus(1'b1, {2'd1, OFF_CMD}, 32'h0000_0005);
        tick(1, r0 + 1);
        bus(1'b0, {2'd1, OFF_CV}, r0);
        bus(1'b0, {2'd1, OFF_SR}, 32'h0004_0004, 32'h0006_0004);
        tick(1, 1);
        bus(1'b0, {2'd1, OFF_SR}, 32'h0000_0010, 32'h0005_0010);
        chk({31'h0, pin_b[1]}, 32'h0000_0000);
        tick(1, 3);
        bus(1'b0, {2'd1, OFF_CV}, 32'h0000_0000);
        // shape 11: triangle to C, then a trigger reverses the direction
        bus(1'b1, {2'd2, OFF_CFG}, mk(2'b11, 2'b01, 2'b00, 1'b0));
        bus(1'b1, {2'd2, OFF_RC}, 32'h0000_0004);
        bus(1'b1, {2'd2, OFF_CMD}, 32'h0000_0005);
        tick(2, 7);
        bus(1'b0, {2'd2, OFF_CV}, 32'h0000_0002);
        bus(1'b1, {2'd2, OFF_CMD}, 32'h0000_0004);
        tick(2, 2);
        bus(1'b0, {2'd2, OFF_CV}, 32'h0000_0003);
        $display("test shapes 10 and 11 done");
        // every source and edge; a foreign source pulses first as a decoy
        for (int s = 0; s < 4; s++) begin
            for (int e = 0; e < 4; e++) begin
                bus(1'b1, {2'd0, OFF_CFG}, mk(2'b00, s[1:0], e[1:0], 1'b0)
                    | 32'h0030_0000);
                @(posedge clk_sys_in); // oe settles at the write edge
                chk({31'h0, pin_b_oe[0]}, {31'h0, s != 0});
                pulse((s + 1) % 4);
                pulse(s);
                pin_exp = pin_exp ^ (e == 1 || e == 2);
                bus(1'b0, {2'd0, OFF_SR}, {14'h0, pin_exp, 9'h0, e != 0,
                    7'h0}, 32'h0002_0080);
                chk({31'h0, pin_a[0]}, {31'h0, pin_exp});
            end
        end
        // event and group sync both restart the running count
        bus(1'b1, {2'd0, OFF_CFG}, mk(2'b00, 2'b01, 2'b01, 1'b1));
        tick(0, 5);
        pulse(1);
        tick(0, 1);
        bus(1'b0, {2'd0, OFF_CV}, 32'h0000_0000);
        tick(0, 5);
        bus(1'b1, OFF_GCMD, 32'h0000_0001);
        tick(0, 1);
        bus(1'b0, {2'd0, OFF_CV}, 32'h0000_0000);
        $display("test events done");
        repeat (2) @(posedge clk_sys_in);
        close_out();
    end
endmodule
